// ===== tb_yield_point_detector.sv
// Self-checking bench for the yield point detector
`timescale 1ns/100ps
`default_nettype none
`include "ypd_cfg.svh"
module tb_yield_point_detector;
  localparam int unsigned SCYC = 64;
  logic i_clk_sys, i_rst_n, i_ce, i_start, i_rundown_complete, i_wr, i_rd;
  logic o_spindle_run, o_yield, o_abort, o_post_ok, o_post_nok, o_irq;
  logic [15:0] i_torque, i_angle, y_ang;
  logic [7:0] i_addr, speed, o_event_code;
  logic [31:0] i_wdata, o_rdata, rd_val;
  int num_errors, comparisons, cyc, n;

  ypd_top #(.SAMPLE_CYCLES(SCYC)) u_dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_ce(i_ce),
    .i_torque(i_torque), .i_angle(i_angle), .i_start(i_start),
    .i_rundown_complete(i_rundown_complete), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_spindle_run(o_spindle_run), .o_yield(o_yield),
    .o_abort(o_abort), .o_event_code(o_event_code), .o_post_ok(o_post_ok),
    .o_post_nok(o_post_nok), .o_irq(o_irq));
  ypd_xdcr_model #(.PERIOD(SCYC), .KNEE(40)) u_xdcr (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_run(o_spindle_run), .i_start(i_start), .i_speed(speed), .o_torque(i_torque),
    .o_angle(i_angle));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
    #1;
  endtask
  // Read data are only valid in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 rd_val = o_rdata;
  endtask
  task automatic pulse(input bit rc);
    @(posedge i_clk_sys);
    if (rc) i_rundown_complete <= 1'b1;
    else i_start <= 1'b1;
    @(posedge i_clk_sys);
    i_rundown_complete <= 1'b0;
    i_start <= 1'b0;
    @(negedge i_clk_sys);
  endtask

  task automatic test_reset();
    rd(`YPD_OFS_YCFG);
    chk("ycfg", 32'h0032_0503, rd_val);
    rd(`YPD_OFS_STATUS);
    chk("status", 32'h0000_0000, rd_val);
    wr(8'h24, 32'hFFFF_FFFF);
    rd(8'h24);
    chk("unmapped", 32'h0000_0000, rd_val);
    chk("irq", 32'h0, o_irq);
    // Clock enable low must also block the register port
    @(posedge i_clk_sys);
    i_ce <= 1'b0;
    wr(`YPD_OFS_CTRL, 32'h0000_0003);
    @(posedge i_clk_sys);
    i_ce <= 1'b1;
    rd(`YPD_OFS_CTRL);
    chk("ctrl frozen", 32'h0000_0000, rd_val);
    $display("test_reset done");
  endtask
  task automatic test_strategy();
    wr(`YPD_OFS_THRESH, 32'h0000_FFFF);
    for (int s = 0; s < 8; s++) begin
      wr(`YPD_OFS_CTRL, 32'(s));
      pulse(1'b0);
      chk("spindle run", (s == 2 || s == 3), o_spindle_run);
    end
    $display("test_strategy done");
  endtask
  task automatic test_threshold();
    wr(`YPD_OFS_CTRL, 32'h0000_0002);
    pulse(1'b0);
    repeat (20 * SCYC) @(negedge i_clk_sys);
    rd(`YPD_OFS_STATUS);
    chk("state below threshold", 32'h1, rd_val & 32'h0000_000F);
    chk("yield", 32'h0, o_yield);
    $display("test_threshold done");
  endtask
  task automatic test_yield();
    wr(`YPD_OFS_THRESH, 32'h0000_0032);
    wr(`YPD_OFS_YCFG, 32'h0832_0503);
    wr(`YPD_OFS_IRQ_MASK, 32'h0000_0000);
    pulse(1'b0);
    for (n = 0; n < 6000 && o_yield !== 1'b1; n++) @(negedge i_clk_sys);
    chk("yield", 32'h1, o_yield);
    y_ang = i_angle;
    chk("run past yield", 32'h1, o_spindle_run);
    for (n = 0; n < 2000 && o_spindle_run !== 1'b0; n++) @(negedge i_clk_sys);
    chk("extra angle", 32'h1, (i_angle - y_ang >= 7 && i_angle - y_ang <= 10));
    rd(`YPD_OFS_TRQ_DIFF);
    chk("max difference", 32'h0000_003C, rd_val & 32'h0000_FFFF);
    rd(`YPD_OFS_IRQ_STAT);
    chk("irq status", 32'h0000_0001, rd_val);
    chk("irq masked", 32'h0, o_irq);
    wr(`YPD_OFS_IRQ_MASK, 32'h0000_0001);
    chk("irq unmasked", 32'h1, o_irq);
    wr(`YPD_OFS_IRQ_STAT, 32'h0000_0001);
    chk("irq cleared", 32'h0, o_irq);
    wr(`YPD_OFS_PMIN, 32'h050A_0064);
    wr(`YPD_OFS_PMAX, 32'h0505_FFFF);
    pulse(1'b1);
    repeat (70) @(negedge i_clk_sys);
    chk("post verdict", 32'h1, {o_post_nok, o_post_ok});
    wr(`YPD_OFS_PMAX, 32'h0505_000A);
    pulse(1'b1);
    repeat (70) @(negedge i_clk_sys);
    chk("post verdict", 32'h2, {o_post_nok, o_post_ok});
    rd(`YPD_OFS_IRQ_STAT);
    chk("irq status", 32'h0000_000C, rd_val);
    $display("test_yield done");
  endtask
  task automatic test_abort();
    wr(`YPD_OFS_IRQ_STAT, 32'h0000_000F);
    wr(`YPD_OFS_THRESH, 32'h0000_0000);
    wr(`YPD_OFS_YCFG, 32'h0032_0101);
    speed <= 8'h08;
    pulse(1'b0);
    for (n = 0; n < 1000 && o_abort !== 1'b1; n++) @(negedge i_clk_sys);
    chk("abort", 32'h1, o_abort);
    chk("event code", 32'h0000_0001, o_event_code);
    chk("spindle run", 32'h0, o_spindle_run);
    rd(`YPD_OFS_IRQ_STAT);
    chk("irq status", 32'h0000_0002, rd_val);
    pulse(1'b0);
    chk("abort after start", 32'h0, {o_event_code, o_abort, o_yield});
    $display("test_abort done");
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  // Whole run needs about 5000 cycles
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  initial begin
    i_rst_n = 1'b0;
    i_ce = 1'b1;
    i_start = 1'b0;
    i_rundown_complete = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h00;
    i_wdata = 32'h0000_0000;
    speed = 8'h01;
    repeat (10) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    test_reset();
    test_strategy();
    test_threshold();
    test_yield();
    test_abort();
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ===== ypd_cfg.svh
// Offsets, field positions, reset values and timing counts of the yield point detector
`ifndef YPD_CFG_SVH
`define YPD_CFG_SVH

`define YPD_CLK_HZ 100000000
`define YPD_SAMPLE_RATE_HZ 2000
`define YPD_SAMPLE_CYCLES (`YPD_CLK_HZ / `YPD_SAMPLE_RATE_HZ)

`define YPD_HIST_DEPTH 64
`define YPD_DIV_STEPS 5'h1E

`define YPD_OFS_CTRL 8'h00
`define YPD_OFS_THRESH 8'h04
`define YPD_OFS_YCFG 8'h08
`define YPD_OFS_PMIN 8'h0C
`define YPD_OFS_PMAX 8'h10
`define YPD_OFS_STATUS 8'h14
`define YPD_OFS_TRQ_DIFF 8'h18
`define YPD_OFS_IRQ_STAT 8'h1C
`define YPD_OFS_IRQ_MASK 8'h20

`define YPD_YC_STEP_LSB 0
`define YPD_YC_WIN_LSB 8
`define YPD_YC_RATIO_LSB 16
`define YPD_YC_EXTRA_LSB 24
`define YPD_PC_TRQ_LSB 0
`define YPD_PC_START_LSB 16
`define YPD_PC_LEN_LSB 24

`define YPD_IRQ_YIELD 0
`define YPD_IRQ_ABORT 1
`define YPD_IRQ_OK 2
`define YPD_IRQ_NOK 3

`define YPD_STRAT_YIELD 3'h2
`define YPD_STRAT_YIELD_TQ_OR 3'h3

`define YPD_RST_STEP 6'h03
`define YPD_RST_WIN 6'h05
`define YPD_RST_RATIO 8'h32
`define YPD_MIN_WIN_SAMPLES 14'h0002
`define YPD_EVT_FEW_SAMPLES 8'h01
`define YPD_PCT_FULL 24'h000064

`endif

// ===== ypd_div.sv
// Sequential restoring divider for the window torque mean
`timescale 1ns/100ps
`default_nettype none
`include "ypd_cfg.svh"
module ypd_div
  import ypd_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // Request
  input wire logic i_start,
  input wire logic [29:0] i_dividend,
  input wire logic [13:0] i_divisor,
  // Answer
  output logic o_done,
  output logic [15:0] o_quot
);

  ypd_div_state_type d_r;
  ypd_div_state_type d_nxt;
  logic [14:0] trial;

  always_comb begin
    d_nxt = d_r;
    d_nxt.done = 1'b0;
    trial = {d_r.rem[13:0], d_r.quo[29]};
    if (i_start) begin
      d_nxt.rem = 15'h0000;
      d_nxt.quo = i_dividend;
      d_nxt.den = i_divisor;
      d_nxt.cnt = 5'h00;
      d_nxt.busy = 1'b1;
    end else if (d_r.busy) begin
      d_nxt.quo = {d_r.quo[28:0], 1'b0};
      if (trial >= {1'b0, d_r.den}) begin
        d_nxt.rem = trial - {1'b0, d_r.den};
        d_nxt.quo[0] = 1'b1;
      end else begin
        d_nxt.rem = trial;
      end
      if (d_r.cnt == `YPD_DIV_STEPS - 5'h01) begin
        d_nxt.busy = 1'b0;
        d_nxt.done = 1'b1;
      end else begin
        d_nxt.cnt = d_r.cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      d_r <= '0;
    end else if (i_ce) begin
      d_r <= d_nxt;
    end
  end

  // Mean of 16-bit samples never exceeds 16 bits; saturate only as a guard
  assign o_quot = (d_r.quo[29:16] != 14'h0000) ? 16'hFFFF : d_r.quo[15:0];
  assign o_done = d_r.done;

endmodule
`default_nettype wire

// ===== ypd_pkg.sv
// Types shared by the yield point detector modules
`include "ypd_cfg.svh"
package ypd_pkg;

  typedef enum logic [3:0] {
    ST_IDLE, ST_WAIT_THR, ST_SEARCH, ST_WSUM, ST_WCHK, ST_WDIV, ST_EXTRA, ST_DONE, ST_ABORT
  } ypd_state_type;

  typedef struct packed {
    logic [23:0] sum;
    logic [7:0] cnt;
    logic [15:0] peak;
  } ypd_hist_type;

  typedef struct packed {
    logic [14:0] rem;
    logic [29:0] quo;
    logic [13:0] den;
    logic [4:0] cnt;
    logic busy;
    logic done;
  } ypd_div_state_type;

  typedef struct packed {
    ypd_hist_type [`YPD_HIST_DEPTH-1:0] hist;
    logic [15:0] trq_m;
    logic [15:0] trq_s;
    logic [15:0] ang_m;
    logic [15:0] ang_s;
    logic [15:0] smp_cnt;
    logic [15:0] last_deg;
    logic deg_valid;
    ypd_state_type st;
    logic [2:0] strat;
    logic [15:0] thresh;
    logic [5:0] step;
    logic [5:0] win;
    logic [7:0] ratio;
    logic [7:0] extra;
    logic [15:0] pmin_trq;
    logic [5:0] pmin_start;
    logic [5:0] pmin_len;
    logic [15:0] pmax_trq;
    logic [5:0] pmax_start;
    logic [5:0] pmax_len;
    logic [3:0] irq_mask;
    logic [3:0] irq_stat;
    logic [15:0] next_deg;
    logic [5:0] scan_end;
    logic [5:0] scan_k;
    logic [29:0] wsum;
    logic [13:0] wcnt;
    logic [15:0] avg1;
    logic [15:0] avg2;
    logic [1:0] navg;
    logic [15:0] tmax;
    logic [16:0] diff;
    logic yield;
    logic [15:0] yield_deg;
    logic [7:0] evt;
    logic pc_busy;
    logic [5:0] pc_k;
    logic [5:0] pc_ref;
    logic [15:0] pc_minpk;
    logic [15:0] pc_maxpk;
    logic ok;
    logic nok;
    logic [31:0] rdata;
  } ypd_top_state_type;

endpackage

// ===== ypd_top.sv
// Yield point detector with post-rundown torque window check
//
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "ypd_cfg.svh"
module ypd_top
  import ypd_pkg::*;
#(
  parameter int unsigned SAMPLE_CYCLES = `YPD_SAMPLE_CYCLES
) (
  // Clock, reset, enable
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // Transducer pins
  input wire logic [15:0] i_torque,
  input wire logic [15:0] i_angle,
  // Tightening cycle control
  input wire logic i_start,
  input wire logic i_rundown_complete,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Status outputs
  output logic o_spindle_run,
  output logic o_yield,
  output logic o_abort,
  output logic [7:0] o_event_code,
  output logic o_post_ok,
  output logic o_post_nok,
  output logic o_irq
);

  localparam logic [15:0] SMP_LAST = 16'(SAMPLE_CYCLES - 1);

  ypd_top_state_type s_r;
  ypd_top_state_type s_nxt;

  logic smp;
  logic new_deg;
  logic [15:0] cur_deg;
  logic [5:0] cur_idx;
  logic [5:0] step_eff;
  logic [5:0] win_eff;
  logic yield_en;
  ypd_hist_type scan_e;
  ypd_hist_type pc_e;
  logic [16:0] diff;
  logic [23:0] lhs;
  logic [23:0] rhs;
  logic yield_hit;
  logic div_go;
  logic div_done;
  logic [15:0] div_q;
  logic [3:0] ev;
  logic [3:0] w1c;
  logic in_min;
  logic in_max;
  logic [15:0] min_pk;
  logic [15:0] max_pk;
  logic pc_pass;

  function automatic logic [31:0] reg_read(input ypd_top_state_type s, input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (a == `YPD_OFS_CTRL) begin
      v[2:0] = s.strat;
    end else if (a == `YPD_OFS_THRESH) begin
      v[15:0] = s.thresh;
    end else if (a == `YPD_OFS_YCFG) begin
      v[`YPD_YC_STEP_LSB +: 6] = s.step;
      v[`YPD_YC_WIN_LSB +: 6] = s.win;
      v[`YPD_YC_RATIO_LSB +: 8] = s.ratio;
      v[`YPD_YC_EXTRA_LSB +: 8] = s.extra;
    end else if (a == `YPD_OFS_PMIN) begin
      v[`YPD_PC_TRQ_LSB +: 16] = s.pmin_trq;
      v[`YPD_PC_START_LSB +: 6] = s.pmin_start;
      v[`YPD_PC_LEN_LSB +: 6] = s.pmin_len;
    end else if (a == `YPD_OFS_PMAX) begin
      v[`YPD_PC_TRQ_LSB +: 16] = s.pmax_trq;
      v[`YPD_PC_START_LSB +: 6] = s.pmax_start;
      v[`YPD_PC_LEN_LSB +: 6] = s.pmax_len;
    end else if (a == `YPD_OFS_STATUS) begin
      v[3:0] = 4'(s.st);
      v[4] = s.yield;
      v[5] = s.ok;
      v[6] = s.nok;
      v[7] = s.pc_busy;
      v[15:8] = s.evt;
      v[31:16] = s.avg1;
    end else if (a == `YPD_OFS_TRQ_DIFF) begin
      v[15:0] = s.tmax;
      v[31:16] = s.diff[15:0];
    end else if (a == `YPD_OFS_IRQ_STAT) begin
      v[3:0] = s.irq_stat;
    end else if (a == `YPD_OFS_IRQ_MASK) begin
      v[3:0] = s.irq_mask;
    end
    return v;
  endfunction

  // Interval test for the post check, offset k degrees back from rundown complete
  function automatic logic in_interval(input logic [5:0] k, input logic [5:0] st,
                                       input logic [5:0] len);
    return (k <= st) && (({1'b0, k} + {1'b0, len}) > {1'b0, st});
  endfunction

  ypd_div u_div (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_start(div_go),
    .i_dividend(s_r.wsum),
    .i_divisor(s_r.wcnt),
    .o_done(div_done),
    .o_quot(div_q)
  );

  always_comb begin
    s_nxt = s_r;
    div_go = 1'b0;
    ev = 4'h0;
    w1c = 4'h0;
    // Bus-wide pin values pass two flops; a torn word lasts one sample at most
    s_nxt.trq_m = i_torque;
    s_nxt.trq_s = s_r.trq_m;
    s_nxt.ang_m = i_angle;
    s_nxt.ang_s = s_r.ang_m;
    smp = 1'b0;
    if (s_r.smp_cnt == SMP_LAST) begin
      s_nxt.smp_cnt = 16'h0000;
      smp = 1'b1;
    end else begin
      s_nxt.smp_cnt = s_r.smp_cnt + 16'h0001;
    end
    cur_deg = s_r.ang_s;
    cur_idx = cur_deg[5:0];
    step_eff = (s_r.step == 6'h00) ? 6'h01 : s_r.step;
    win_eff = (s_r.win == 6'h00) ? 6'h01 : s_r.win;
    yield_en = (s_r.strat == `YPD_STRAT_YIELD) || (s_r.strat == `YPD_STRAT_YIELD_TQ_OR);
    new_deg = smp && (!s_r.deg_valid || (cur_deg != s_r.last_deg));

    // Torque history held per degree for the windows and the post check
    if (smp) begin
      if (new_deg) begin
        s_nxt.hist[cur_idx].sum = {8'h00, s_r.trq_s};
        s_nxt.hist[cur_idx].cnt = 8'h01;
        s_nxt.hist[cur_idx].peak = s_r.trq_s;
      end else if (s_r.hist[cur_idx].cnt != 8'hFF) begin
        s_nxt.hist[cur_idx].sum = s_r.hist[cur_idx].sum + {8'h00, s_r.trq_s};
        s_nxt.hist[cur_idx].cnt = s_r.hist[cur_idx].cnt + 8'h01;
        if (s_r.trq_s > s_r.hist[cur_idx].peak) begin
          s_nxt.hist[cur_idx].peak = s_r.trq_s;
        end
      end
      s_nxt.last_deg = cur_deg;
      s_nxt.deg_valid = 1'b1;
    end

    // Yield evaluation arithmetic
    scan_e = s_r.hist[s_r.scan_end - s_r.scan_k];
    diff = {1'b0, div_q} - {1'b0, s_r.avg2};
    lhs = 24'(diff[15:0]) * `YPD_PCT_FULL;
    rhs = 24'(s_r.tmax) * 24'(s_r.ratio);
    // A falling average always counts as below the ratio once a maximum exists
    yield_hit = (s_r.navg == 2'h2) && (s_r.tmax != 16'h0000) &&
                (diff[16] || (lhs < rhs));

    case (s_r.st)
      ST_WAIT_THR: begin
        if (smp && (s_r.trq_s >= s_r.thresh)) begin
          s_nxt.st = ST_SEARCH;
          s_nxt.next_deg = cur_deg + {10'h000, step_eff};
        end
      end
      ST_SEARCH: begin
        if (new_deg && (cur_deg >= s_r.next_deg)) begin
          s_nxt.scan_end = cur_idx - 6'h01;
          s_nxt.scan_k = 6'h00;
          s_nxt.wsum = 30'h0000_0000;
          s_nxt.wcnt = 14'h0000;
          s_nxt.next_deg = cur_deg + {10'h000, step_eff};
          s_nxt.st = ST_WSUM;
        end
      end
      ST_WSUM: begin
        s_nxt.wsum = s_r.wsum + {6'h00, scan_e.sum};
        s_nxt.wcnt = s_r.wcnt + {6'h00, scan_e.cnt};
        if (s_r.scan_k == win_eff - 6'h01) begin
          s_nxt.st = ST_WCHK;
        end else begin
          s_nxt.scan_k = s_r.scan_k + 6'h01;
        end
      end
      ST_WCHK: begin
        if (s_r.wcnt < `YPD_MIN_WIN_SAMPLES) begin
          s_nxt.evt = `YPD_EVT_FEW_SAMPLES;
          s_nxt.st = ST_ABORT;
          ev[`YPD_IRQ_ABORT] = 1'b1;
        end else begin
          div_go = 1'b1;
          s_nxt.st = ST_WDIV;
        end
      end
      ST_WDIV: begin
        if (div_done) begin
          if ((s_r.navg == 2'h2) && !diff[16] && (diff[15:0] > s_r.tmax)) begin
            s_nxt.tmax = diff[15:0];
          end
          if (s_r.navg == 2'h2) begin
            s_nxt.diff = diff;
          end
          s_nxt.avg2 = s_r.avg1;
          s_nxt.avg1 = div_q;
          s_nxt.navg = (s_r.navg == 2'h2) ? 2'h2 : s_r.navg + 2'h1;
          if (yield_hit) begin
            s_nxt.yield = 1'b1;
            s_nxt.yield_deg = s_r.last_deg;
            ev[`YPD_IRQ_YIELD] = 1'b1;
            s_nxt.st = (s_r.extra == 8'h00) ? ST_DONE : ST_EXTRA;
          end else begin
            s_nxt.st = ST_SEARCH;
          end
        end
      end
      ST_EXTRA: begin
        // Checked on samples only, so the stop lands on the first degree at or past target
        if (smp && (cur_deg >= s_r.yield_deg + {8'h00, s_r.extra})) begin
          s_nxt.st = ST_DONE;
        end
      end
      default: begin
      end
    endcase

    // Post check scans 64 degrees back from rundown complete
    pc_e = s_r.hist[s_r.pc_ref - s_r.pc_k];
    in_min = in_interval(s_r.pc_k, s_r.pmin_start, s_r.pmin_len);
    in_max = in_interval(s_r.pc_k, s_r.pmax_start, s_r.pmax_len);
    min_pk = s_r.pc_minpk;
    max_pk = s_r.pc_maxpk;
    if ((pc_e.cnt != 8'h00) && in_min && (pc_e.peak > min_pk)) begin
      min_pk = pc_e.peak;
    end
    if ((pc_e.cnt != 8'h00) && in_max && (pc_e.peak > max_pk)) begin
      max_pk = pc_e.peak;
    end
    // Minimum window must reach its floor, maximum window must not exceed its ceiling
    pc_pass = (min_pk >= s_r.pmin_trq) && (max_pk <= s_r.pmax_trq);
    if (s_r.pc_busy) begin
      s_nxt.pc_minpk = min_pk;
      s_nxt.pc_maxpk = max_pk;
      if (s_r.pc_k == 6'h3F) begin
        s_nxt.pc_busy = 1'b0;
        s_nxt.ok = pc_pass;
        s_nxt.nok = !pc_pass;
        ev[`YPD_IRQ_OK] = pc_pass;
        ev[`YPD_IRQ_NOK] = !pc_pass;
      end else begin
        s_nxt.pc_k = s_r.pc_k + 6'h01;
      end
    end else if (i_rundown_complete) begin
      s_nxt.pc_busy = 1'b1;
      s_nxt.pc_k = 6'h00;
      s_nxt.pc_ref = s_r.last_deg[5:0];
      s_nxt.pc_minpk = 16'h0000;
      s_nxt.pc_maxpk = 16'h0000;
    end

    // New tightening wipes the previous run
    if (i_start) begin
      s_nxt.hist = '0;
      s_nxt.deg_valid = 1'b0;
      s_nxt.navg = 2'h0;
      s_nxt.avg1 = 16'h0000;
      s_nxt.avg2 = 16'h0000;
      s_nxt.tmax = 16'h0000;
      s_nxt.diff = 17'h00000;
      s_nxt.yield = 1'b0;
      s_nxt.evt = 8'h00;
      s_nxt.ok = 1'b0;
      s_nxt.nok = 1'b0;
      s_nxt.pc_busy = 1'b0;
      s_nxt.st = yield_en ? ST_WAIT_THR : ST_IDLE;
    end

    // Register writes
    if (i_wr) begin
      if (i_addr == `YPD_OFS_CTRL) begin
        s_nxt.strat = i_wdata[2:0];
      end else if (i_addr == `YPD_OFS_THRESH) begin
        s_nxt.thresh = i_wdata[15:0];
      end else if (i_addr == `YPD_OFS_YCFG) begin
        s_nxt.step = i_wdata[`YPD_YC_STEP_LSB +: 6];
        s_nxt.win = i_wdata[`YPD_YC_WIN_LSB +: 6];
        s_nxt.ratio = i_wdata[`YPD_YC_RATIO_LSB +: 8];
        s_nxt.extra = i_wdata[`YPD_YC_EXTRA_LSB +: 8];
      end else if (i_addr == `YPD_OFS_PMIN) begin
        s_nxt.pmin_trq = i_wdata[`YPD_PC_TRQ_LSB +: 16];
        s_nxt.pmin_start = i_wdata[`YPD_PC_START_LSB +: 6];
        s_nxt.pmin_len = i_wdata[`YPD_PC_LEN_LSB +: 6];
      end else if (i_addr == `YPD_OFS_PMAX) begin
        s_nxt.pmax_trq = i_wdata[`YPD_PC_TRQ_LSB +: 16];
        s_nxt.pmax_start = i_wdata[`YPD_PC_START_LSB +: 6];
        s_nxt.pmax_len = i_wdata[`YPD_PC_LEN_LSB +: 6];
      end else if (i_addr == `YPD_OFS_IRQ_STAT) begin
        w1c = i_wdata[3:0];
      end else if (i_addr == `YPD_OFS_IRQ_MASK) begin
        s_nxt.irq_mask = i_wdata[3:0];
      end
    end
    // Set beats a simultaneous clear so no event is lost
    s_nxt.irq_stat = (s_r.irq_stat & ~w1c) | ev;
    s_nxt.rdata = i_rd ? reg_read(s_r, i_addr) : 32'h0000_0000;
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_r <= '0;
      s_r.step <= `YPD_RST_STEP;
      s_r.win <= `YPD_RST_WIN;
      s_r.ratio <= `YPD_RST_RATIO;
    end else if (i_ce) begin
      s_r <= s_nxt;
    end
  end

  // DONE, ABORT and IDLE all release the spindle
  assign o_spindle_run = (s_r.st == ST_WAIT_THR) || (s_r.st == ST_SEARCH) ||
                         (s_r.st == ST_WSUM) || (s_r.st == ST_WCHK) ||
                         (s_r.st == ST_WDIV) || (s_r.st == ST_EXTRA);
  assign o_yield = s_r.yield;
  assign o_abort = (s_r.st == ST_ABORT);
  assign o_event_code = s_r.evt;
  assign o_post_ok = s_r.ok;
  assign o_post_nok = s_r.nok;
  assign o_irq = |(s_r.irq_stat & s_r.irq_mask);
  assign o_rdata = s_r.rdata;

endmodule
`default_nettype wire

// ===== ypd_top_assertions.sv
// Port-level checks of the yield point detector
`timescale 1ns/100ps
`default_nettype none
module ypd_top_chk (
  // Watched ports
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_start,
  input wire logic i_rundown_complete,
  input wire logic o_spindle_run,
  input wire logic o_yield,
  input wire logic o_abort,
  input wire logic [7:0] o_event_code,
  input wire logic o_post_ok,
  input wire logic o_post_nok
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  chk_run_until_yield: assert property (
    $fell(o_spindle_run) && !$past(i_start) && !o_abort |-> o_yield)
    else $error("spindle stopped before yield");
  chk_abort_code: assert property (
    o_abort |-> o_event_code == 8'h01)
    else $error("abort without event code");
  chk_abort_halts: assert property (
    o_abort |-> !o_spindle_run)
    else $error("spindle runs while aborted");
  chk_abort_from_run: assert property (
    $rose(o_abort) |-> $past(o_spindle_run))
    else $error("abort outside a tightening");
  chk_start_clears: assert property (
    i_start && i_ce |=> !o_yield && !o_abort && o_event_code == 8'h00 && !o_post_ok && !o_post_nok)
    else $error("start left old results");
  chk_verdict_single: assert property (
    !(o_post_ok && o_post_nok))
    else $error("both verdicts set");
  chk_verdict_time: assert property (
    $rose(o_post_ok) || $rose(o_post_nok) |-> $past(i_rundown_complete, 64)
    || $past(i_rundown_complete, 65) || $past(i_rundown_complete, 66))
    else $error("verdict not tied to rundown complete");
  chk_yield_holds: assert property (
    o_yield && !i_start |=> o_yield)
    else $error("yield flag dropped");
  chk_yield_in_run: assert property (
    $rose(o_yield) |-> $past(o_spindle_run))
    else $error("yield outside a search");
endmodule
bind ypd_top ypd_top_chk u_chk (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_ce(i_ce),
  .i_start(i_start), .i_rundown_complete(i_rundown_complete), .o_spindle_run(o_spindle_run),
  .o_yield(o_yield), .o_abort(o_abort), .o_event_code(o_event_code), .o_post_ok(o_post_ok),
  .o_post_nok(o_post_nok));
`default_nettype wire

// ===== ypd_xdcr_model.sv
// Behavioural transducer and spindle drive facing the detector
`timescale 1ns/100ps
`default_nettype none
module ypd_xdcr_model #(
  parameter int unsigned PERIOD = 64,
  parameter int unsigned KNEE = 40
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Drive control
  input wire logic i_run,
  input wire logic i_start,
  input wire logic [7:0] i_speed,
  // Transducer outputs
  output logic [15:0] o_torque,
  output logic [15:0] o_angle
);
  int unsigned tmr;
  // Stiff joint below the knee, yielding joint above it
  assign o_torque = (o_angle < KNEE) ? 16'(o_angle * 10) : 16'(KNEE * 9 + o_angle);
  // Angle moves only while the detector keeps the spindle turning
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tmr <= 0;
      o_angle <= 16'h0000;
    end else begin
      tmr <= (tmr == PERIOD - 1) ? 0 : tmr + 1;
      if (i_start) begin
        o_angle <= 16'h0000;
      end else if (i_run && tmr == PERIOD - 1) begin
        o_angle <= o_angle + 16'(i_speed);
      end
    end
  end
endmodule
`default_nettype wire
